// ==== core/serial_mram_spi_map.vh ====
// Purpose: constants for the serial memory pin interface front end
// Assumes: one 250 MHz reference clock samples every pin
// Notes:   status layout and opcode values are local choices
//
// Summary of operation
// - chip select high means standby, no bus activity
// - deselected: inputs ignored, all outputs released
// - chip select low enables device, awaits instruction
// - protect bit and low pin block status writes
// - write protect pin honoured in single lane only
// - single rate captures inputs on rising edges
// - single rate launches outputs on falling edges
// - double rate captures command on rising edges only
// - double rate address, data use both edges
// - clock mode 0 for single and double rate
// - clock mode 3 for single rate only
// - dual and quad make pins bidirectional lanes
// - four lane protocol single rate up to 54 MHz
// - top or bottom bit plus three protect bits
// - 64-bit unique id and programmable serial number
// - 256-byte auxiliary array, programmable, write protectable
// - eight-bit instruction shifted in each selection
`ifndef SERIAL_MRAM_SPI_MAP_VH
`define SERIAL_MRAM_SPI_MAP_VH
`define REF_CLK_MHZ    250
`define SCLK_MAX_MHZ   54
`define LANES_ONE      2'h0
`define LANES_TWO      2'h1
`define LANES_FOUR     2'h2
`define INSTR_BITS     4'h8
`define OP_WRITE_SR    8'h01
`define SR_RESET       8'h00
`define SR_SRP         7
`define SR_TB          5
`define SR_BP_HI       4
`define SR_BP_LO       2
`define SR_WR_MASK     8'hbc
// unique id default value is arbitrary
`define UID_DEFAULT    64'h0123_4567_89ab_cdef
`define AUX_DEPTH      256
`endif

// ==== core/serial_mram_spi_pin_interface.v ====
// Purpose: pin-level serial interface front end of a serial memory
// Assumes: sclk, cs_n and io_in are asynchronous and pass two flops
// Notes:   edges are found by oversampling, so sclk must stay well below ref_clk / 4
`timescale 1ns/1ps
`include "serial_mram_spi_map.vh"

module serial_mram_spi_pin_interface #(
  parameter [63:0] UNIQUE_ID = `UID_DEFAULT
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire [3:0]  io_in,
  output wire [3:0]  io_out,
  output wire [3:0]  io_oe_n,
  input  wire [1:0]  cmd_lanes,
  input  wire [1:0]  xfer_lanes,
  input  wire        ddr_en,
  input  wire        read_phase,
  input  wire [7:0]  tx_data,
  output wire        tx_req,
  output wire [7:0]  instr,
  output wire        instr_valid,
  output wire [7:0]  rx_byte,
  output wire        rx_valid,
  output wire        selected,
  output wire        clk_mode3,
  output wire [7:0]  status_reg,
  output wire        wrsr_blocked,
  input  wire        sn_we,
  input  wire [63:0] sn_wdata,
  output wire [63:0] serial_num,
  output wire [63:0] unique_id,
  input  wire        aux_we,
  input  wire [7:0]  aux_addr,
  input  wire [7:0]  aux_wdata,
  input  wire        aux_lock,
  output wire [7:0]  aux_rdata,
  output wire        aux_refused
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_CMD  = 4'b0010;
  localparam [3:0] ST_IN   = 4'b0100;
  localparam [3:0] ST_OUT  = 4'b1000;

  reg        sclk_s1_r;
  reg        sclk_s2_r;
  reg        sclk_s3_r;
  reg        cs_s1_r;
  reg        cs_s2_r;
  reg        cs_s3_r;
  reg [3:0]  io_s1_r;
  reg [3:0]  io_s2_r;
  reg [3:0]  state_r;
  reg [3:0]  cnt_r;
  reg [7:0]  rxsh_r;
  reg [7:0]  txsh_r;
  reg [3:0]  io_out_r;
  reg [3:0]  io_oe_n_r;
  reg        tx_req_r;
  reg [7:0]  instr_r;
  reg        instr_valid_r;
  reg [7:0]  rx_byte_r;
  reg        rx_valid_r;
  reg        mode3_r;
  reg [7:0]  sr_r;
  reg        wr_pend_r;
  reg        wrsr_blocked_r;
  reg        selected_r;
  reg [63:0] sn_r;
  reg [63:0] uid_r;
  reg [7:0]  aux_rdata_r;
  reg        aux_refused_r;
  reg [7:0]  aux_mem [0:`AUX_DEPTH-1];

  wire       rise;
  wire       fall;
  wire       cs_fall;
  wire       ddr_act;
  wire       samp_in;
  wire       launch;
  wire [3:0] cmd_cnt_nxt;
  wire [3:0] in_cnt_nxt;
  wire [7:0] cmd_sh_nxt;
  wire [7:0] in_sh_nxt;
  wire       single_mode;
  wire       sr_locked;

  function [3:0] lane_bits;
    input [1:0] ln;
    begin
      case (ln)
        `LANES_TWO:  lane_bits = 4'h2;
        `LANES_FOUR: lane_bits = 4'h4;
        default:     lane_bits = 4'h1;
      endcase
    end
  endfunction
  function [7:0] shift_in;
    input [7:0] sh;
    input [3:0] io;
    input [1:0] ln;
    begin
      case (ln)
        `LANES_TWO:  shift_in = {sh[5:0], io[1:0]};
        `LANES_FOUR: shift_in = {sh[3:0], io[3:0]};
        default:     shift_in = {sh[6:0], io[0]};
      endcase
    end
  endfunction
  // single lane output goes on the dedicated output pin, io[1]
  function [3:0] out_bits;
    input [7:0] sh;
    input [1:0] ln;
    begin
      case (ln)
        `LANES_TWO:  out_bits = {2'h0, sh[7:6]};
        `LANES_FOUR: out_bits = sh[7:4];
        default:     out_bits = {2'h0, sh[7], 1'h0};
      endcase
    end
  endfunction
  function [3:0] lane_oe_n;
    input [1:0] ln;
    begin
      case (ln)
        `LANES_TWO:  lane_oe_n = 4'hc;
        `LANES_FOUR: lane_oe_n = 4'h0;
        default:     lane_oe_n = 4'hd;
      endcase
    end
  endfunction
  function [7:0] shift_out;
    input [7:0] sh;
    input [1:0] ln;
    begin
      case (ln)
        `LANES_TWO:  shift_out = {sh[5:0], 2'h0};
        `LANES_FOUR: shift_out = {sh[3:0], 4'h0};
        default:     shift_out = {sh[6:0], 1'h0};
      endcase
    end
  endfunction

  // first stages feed only the second stages
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      cs_s1_r   <= 1'b0;
      cs_s2_r   <= 1'b0;
      cs_s3_r   <= 1'b0;
      io_s1_r   <= 4'h0;
      io_s2_r   <= 4'h0;
    end
    else
    begin
      sclk_s1_r <= sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      cs_s1_r   <= cs_n;
      cs_s2_r   <= cs_s1_r;
      cs_s3_r   <= cs_s2_r;
      io_s1_r   <= io_in;
      io_s2_r   <= io_s1_r;
    end
  end

  assign rise        = sclk_s2_r & ~sclk_s3_r;
  assign fall        = ~sclk_s2_r & sclk_s3_r;
  // history resets low, so a select already low at power-up is no falling edge
  assign cs_fall     = ~cs_s2_r & cs_s3_r;
  assign ddr_act     = ddr_en & ~mode3_r;
  assign samp_in     = rise | (fall & ddr_act);
  assign launch      = fall | (rise & ddr_act);
  assign cmd_cnt_nxt = cnt_r + lane_bits(cmd_lanes);
  assign in_cnt_nxt  = cnt_r + lane_bits(xfer_lanes);
  assign cmd_sh_nxt  = shift_in(rxsh_r, io_s2_r, cmd_lanes);
  assign in_sh_nxt   = shift_in(rxsh_r, io_s2_r, xfer_lanes);
  assign single_mode = (cmd_lanes == `LANES_ONE) & (xfer_lanes == `LANES_ONE);
  // in dual or quad the protect pin never blocks; only quad uses it as a data lane
  assign sr_locked   = sr_r[`SR_SRP] & ~io_s2_r[2] & single_mode;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r        <= ST_IDLE;
      selected_r     <= 1'b0;
      cnt_r          <= 4'h0;
      rxsh_r         <= 8'h00;
      txsh_r         <= 8'h00;
      io_out_r       <= 4'h0;
      io_oe_n_r      <= 4'hf;
      tx_req_r       <= 1'b0;
      instr_r        <= 8'h00;
      instr_valid_r  <= 1'b0;
      rx_byte_r      <= 8'h00;
      rx_valid_r     <= 1'b0;
      mode3_r        <= 1'b0;
      sr_r           <= `SR_RESET;
      wr_pend_r      <= 1'b0;
      wrsr_blocked_r <= 1'b0;
    end
    else
    begin
      tx_req_r       <= 1'b0;
      instr_valid_r  <= 1'b0;
      rx_valid_r     <= 1'b0;
      wrsr_blocked_r <= 1'b0;
      if (cs_s2_r)
      begin
        // deselect drops any partial instruction and frees the pins
        state_r   <= ST_IDLE;
        selected_r <= 1'b0;
        cnt_r     <= 4'h0;
        wr_pend_r <= 1'b0;
        io_oe_n_r <= 4'hf;
      end
      else if (cs_fall)
      begin
        state_r <= ST_CMD;
        selected_r <= 1'b1;
        cnt_r   <= 4'h0;
        mode3_r <= sclk_s2_r;
      end
      else
      begin
        case (state_r)
          ST_CMD:
          begin
            if (rise)
            begin
              rxsh_r <= cmd_sh_nxt;
              if (cmd_cnt_nxt >= `INSTR_BITS)
              begin
                instr_r       <= cmd_sh_nxt;
                instr_valid_r <= 1'b1;
                wr_pend_r     <= (cmd_sh_nxt == `OP_WRITE_SR);
                cnt_r         <= 4'h0;
                state_r       <= ST_IN;
              end
              else
              begin
                cnt_r <= cmd_cnt_nxt;
              end
            end
          end
          ST_IN:
          begin
            if (launch & read_phase & (cnt_r == 4'h0))
            begin
              // turnaround only at a byte boundary
              io_out_r  <= out_bits(tx_data, xfer_lanes);
              io_oe_n_r <= lane_oe_n(xfer_lanes);
              txsh_r    <= shift_out(tx_data, xfer_lanes);
              cnt_r     <= lane_bits(xfer_lanes);
              tx_req_r  <= 1'b1;
              state_r   <= ST_OUT;
            end
            else if (samp_in)
            begin
              rxsh_r <= in_sh_nxt;
              if (in_cnt_nxt >= `INSTR_BITS)
              begin
                rx_byte_r  <= in_sh_nxt;
                rx_valid_r <= 1'b1;
                cnt_r      <= 4'h0;
                wr_pend_r  <= 1'b0;
                if (wr_pend_r & sr_locked)
                  wrsr_blocked_r <= 1'b1;
                else if (wr_pend_r)
                  sr_r <= (sr_r & ~`SR_WR_MASK) | (in_sh_nxt & `SR_WR_MASK);
              end
              else
              begin
                cnt_r <= in_cnt_nxt;
              end
            end
          end
          ST_OUT:
          begin
            if (launch)
            begin
              if (cnt_r >= `INSTR_BITS)
              begin
                io_out_r <= out_bits(tx_data, xfer_lanes);
                txsh_r   <= shift_out(tx_data, xfer_lanes);
                cnt_r    <= lane_bits(xfer_lanes);
                tx_req_r <= 1'b1;
              end
              else
              begin
                io_out_r <= out_bits(txsh_r, xfer_lanes);
                txsh_r   <= shift_out(txsh_r, xfer_lanes);
                cnt_r    <= in_cnt_nxt;
              end
            end
          end
          default:
          begin
            state_r    <= ST_IDLE;
            selected_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // identity and serial number; the id is fixed, the number user written
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      uid_r <= UNIQUE_ID;
      sn_r  <= 64'h0;
    end
    else if (sn_we)
    begin
      sn_r <= sn_wdata;
    end
  end

  // auxiliary array is not reset: its contents model non-volatile storage
  always @(posedge ref_clk)
  begin
    if (aux_we & ~aux_lock)
      aux_mem[aux_addr] <= aux_wdata;
    aux_rdata_r <= aux_mem[aux_addr];
  end

  always @(posedge ref_clk)
  begin
    if (rst)
      aux_refused_r <= 1'b0;
    else
      aux_refused_r <= aux_we & aux_lock;
  end

  assign io_out       = io_out_r;
  assign io_oe_n      = io_oe_n_r;
  assign tx_req       = tx_req_r;
  assign instr        = instr_r;
  assign instr_valid  = instr_valid_r;
  assign rx_byte      = rx_byte_r;
  assign rx_valid     = rx_valid_r;
  assign selected     = selected_r;
  assign clk_mode3    = mode3_r;
  assign status_reg   = sr_r;
  assign wrsr_blocked = wrsr_blocked_r;
  assign serial_num   = sn_r;
  assign unique_id    = uid_r;
  assign aux_rdata    = aux_rdata_r;
  assign aux_refused  = aux_refused_r;

endmodule

// ==== test/serial_mram_spi_pin_interface_props.sv ====
// Purpose: port-level temporal checks of the serial memory pin interface
// Assumes: host holds cs_n and sclk levels for several ref_clk cycles
// Notes:   windows allow for the two-flop synchronisers on every pin
`timescale 1ns/1ps
module serial_mram_spi_pin_interface_props #(
  parameter [63:0] UNIQUE_ID = 64'h0
) (
  input wire        ref_clk,
  input wire        rst,
  input wire        sclk,
  input wire        cs_n,
  input wire [3:0]  io_out,
  input wire [3:0]  io_oe_n,
  input wire [1:0]  cmd_lanes,
  input wire [1:0]  xfer_lanes,
  input wire        ddr_en,
  input wire        instr_valid,
  input wire        selected,
  input wire [7:0]  status_reg,
  input wire        wrsr_blocked,
  input wire        sn_we,
  input wire [63:0] sn_wdata,
  input wire [63:0] serial_num,
  input wire [63:0] unique_id,
  input wire        aux_we,
  input wire        aux_lock,
  input wire        aux_refused
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence idle_s;
    cs_n [*4];
  endsequence
  sequence sel_s;
    !cs_n [*7];
  endsequence
  standby_sel_a: assert property (cs_n [*6] |-> !selected) else $error("selected while deselected");
  release_oe_a: assert property (cs_n [*6] |-> io_oe_n == 4'hf) else $error("pins driven while deselected");
  enable_sel_a: assert property (idle_s ##1 sel_s |-> selected) else $error("no selection");
  wp_block_a: assert property (wrsr_blocked |-> status_reg[7] && (cmd_lanes == 2'h0 || cmd_lanes == 2'h3)
    && (xfer_lanes == 2'h0 || xfer_lanes == 2'h3) ##1 $stable(status_reg)) else $error("bad status refusal");
  sr_mask_a: assert property ((status_reg & 8'h43) == 8'h00) else $error("status bit outside fields");
  uid_hold_a: assert property (unique_id == UNIQUE_ID) else $error("unique id wrong");
  sn_write_a: assert property (sn_we |=> serial_num == $past(sn_wdata)) else $error("serial not written");
  aux_lock_a: assert property (aux_we && aux_lock |=> aux_refused) else $error("locked write not refused");
  aux_open_a: assert property (!(aux_we && aux_lock) |=> !aux_refused) else $error("stray refusal");
  sdr_launch_a: assert property ($changed(io_out) && !ddr_en |-> $past(sclk, 5) && !$past(sclk, 2))
    else $error("output not launched on falling edge");
  instr_pulse_a: assert property (instr_valid |=> !instr_valid) else $error("instruction pulse too long");
endmodule
bind serial_mram_spi_pin_interface serial_mram_spi_pin_interface_props #(.UNIQUE_ID(UNIQUE_ID)) chk (.*);

// ==== test/serial_mram_spi_pin_interface_tb_top.sv ====
// Purpose: self-checking bench for the serial memory pin interface
// Assumes: host model owns the pins, bench owns the user side
// Notes:   expected bytes are queued before they are sent
`timescale 1ns/1ps
`include "serial_mram_spi_map.vh"
module serial_mram_spi_pin_interface_tb_top;
  reg         ref_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [1:0]  cmd_lanes = 2'h0;
  reg  [1:0]  xfer_lanes = 2'h0;
  reg         ddr_en = 1'b0;
  reg         read_phase = 1'b0;
  reg  [7:0]  tx_data = 8'h00;
  reg         sn_we = 1'b0;
  reg  [63:0] sn_wdata = 64'h0;
  reg         aux_we = 1'b0;
  reg  [7:0]  aux_addr = 8'h00;
  reg  [7:0]  aux_wdata = 8'h00;
  reg         aux_lock = 1'b0;
  reg  [7:0]  v;
  reg  [7:0]  q;
  wire        sclk, cs_n, tx_req, instr_valid, rx_valid, selected, clk_mode3, wrsr_blocked, aux_refused;
  wire [3:0]  io_in, io_out, io_oe_n;
  wire [7:0]  instr, rx_byte, status_reg, aux_rdata;
  wire [63:0] serial_num, unique_id;
  integer     error_cnt = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     blk = 0;
  integer     txr = 0;
  integer     k;
  int         exp_q[$];
  serial_mram_spi_pin_interface dut (.*);
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .io_to_dev(io_in), .dev_io(io_out), .dev_oe_n(io_oe_n));
  always #2 ref_clk = ~ref_clk;
  task summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task check(input [63:0] got, input [63:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  function integer lw(input [1:0] c);
    lw = (c == 2'h1) ? 2 : (c == 2'h2) ? 4 : 1;
  endfunction
  // every received byte is compared against the queue in arrival order
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt = error_cnt + 1;
      $display("mismatch at %0t: timeout", $time);
      summarize;
    end
    else
    begin
      if (instr_valid === 1'b1 || rx_valid === 1'b1)
      begin
        if (exp_q.size() == 0)
          check(1, 0);
        else
          check({instr_valid, instr_valid ? instr : rx_byte}, exp_q.pop_front());
      end
      if (wrsr_blocked === 1'b1)
        blk = blk + 1;
      if (tx_req === 1'b1)
        txr = txr + 1;
    end
  end
  task setl(input [1:0] c, input [1:0] x, input dd);
    begin
      @(negedge ref_clk);
      cmd_lanes = c;
      xfer_lanes = x;
      ddr_en = dd;
    end
  endtask
  task frame(input m3, input [7:0] cmd, input integer n, input [7:0] d0);
    integer i;
    begin
      host.start(m3);
      exp_q.push_back({1'b1, cmd});
      host.xfer(cmd, lw(cmd_lanes), 1'b0, 8);
      check(clk_mode3, m3);
      for (i = 0; i < n; i = i + 1)
      begin
        v = (i == 0) ? d0 : $urandom;
        exp_q.push_back({1'b0, v});
        host.xfer(v, lw(xfer_lanes), ddr_en && !m3, 8);
      end
    end
  endtask
  task fin;
    begin
      host.stop;
      check(exp_q.size(), 0);
    end
  endtask
  task auxw(input lk, input [7:0] dt);
    begin
      @(negedge ref_clk);
      aux_lock = lk;
      aux_wdata = dt;
      aux_we = 1'b1;
      @(negedge ref_clk) aux_we = 1'b0;
      @(negedge ref_clk);
    end
  endtask
  initial
  begin
    void'($urandom(34));
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    host.xfer(8'h5a, 1, 1'b0, 8);
    fin;
    host.xfer(8'hc3, 1, 1'b0, 8);
    fin;
    for (k = 0; k < 12; k = k + 1)
    begin
      setl(k % 3, k % 3, k / 6);
      frame(k / 3 % 2, $urandom | 8'h80, 3, $urandom);
      fin;
    end
    setl(2'h0, 2'h0, 1'b0);
    frame(1'b0, 8'h9c, 1, $urandom);
    host.xfer(8'hff, 1, 1'b0, 4);
    host.stop;
    frame(1'b0, $urandom | 8'h80, 1, $urandom);
    fin;
    frame(1'b0, `OP_WRITE_SR, 1, 8'hff);
    fin;
    check(status_reg, 8'hff & `SR_WR_MASK);
    host.wp = 1'b0;
    frame(1'b0, `OP_WRITE_SR, 1, 8'h00);
    fin;
    check(status_reg, 8'hff & `SR_WR_MASK);
    check(blk, 1);
    setl(2'h2, 2'h2, 1'b0);
    frame(1'b0, `OP_WRITE_SR, 1, 8'h00);
    fin;
    check(status_reg, 8'h00);
    setl(2'h0, 2'h0, 1'b0);
    host.wp = 1'b1;
    tx_data = $urandom;
    frame(1'b0, $urandom | 8'h80, 0, 8'h00);
    repeat (8) @(negedge ref_clk);
    read_phase = 1'b1;
    host.read(q);
    @(negedge ref_clk) read_phase = 1'b0;
    fin;
    check(q, tx_data);
    check(txr, 2);
    @(negedge ref_clk) sn_wdata = {$urandom, $urandom};
    sn_we = 1'b1;
    @(negedge ref_clk) sn_we = 1'b0;
    check(serial_num, sn_wdata);
    check(unique_id, `UID_DEFAULT);
    aux_addr = $urandom;
    v = $urandom;
    auxw(1'b0, v);
    check(aux_rdata, v);
    auxw(1'b1, ~v);
    check(aux_rdata, v);
    summarize;
  end
endmodule

// ==== test/spi_host_model.sv ====
// Purpose: behavioural host driving select, clock and data lanes
// Assumes: sclk period 48 ns, below the device maximum
// Notes:   lanes nobody drives show the inverse of the last value
`timescale 1ns/1ps
module spi_host_model (
  output reg        sclk = 1'b0,
  output reg        cs_n = 1'b0,
  output wire [3:0] io_to_dev,
  input  wire [3:0] dev_io,
  input  wire [3:0] dev_oe_n
);
  reg       en = 1'b0;
  reg       wp = 1'b1;
  reg       cpol = 1'b0;
  reg [3:0] d = 4'h4;
  // wp stays driven even while the data lanes are released
  assign io_to_dev = (~dev_oe_n & dev_io) | (dev_oe_n & (en ? d : {~d[3], d[2], ~d[1:0]}));
  task start(input m3);
    begin
      cpol = m3;
      sclk = m3;
      #31.3 cs_n = 1'b0;
      #24;
    end
  endtask
  task xfer(input [7:0] b, input integer w, input ddr, input integer nb);
    integer   p;
    reg [7:0] t;
    begin
      p = 0;
      while (p < nb)
      begin
        #12;
        if (!sclk || ddr)
        begin
          t = b << p;
          d = t >> (8 - w);
          if (w == 1)
            d[2] = wp;
          en = 1'b1;
          p = p + w;
        end
        #12 sclk = ~sclk;
      end
    end
  endtask
  task read(output [7:0] q);
    integer k;
    begin
      en = 1'b0;
      for (k = 0; k < 8; k = k + 1)
      begin
        #24 sclk = 1'b0;
        #24 sclk = 1'b1;
        q = {q[6:0], io_to_dev[1]};
      end
    end
  endtask
  task stop;
    begin
      #12 sclk = cpol;
      #12 en = 1'b0;
      cs_n = 1'b1;
      #60;
    end
  endtask
endmodule
